// >>> hdl/rssr_pkg.sv
// rssr_pkg: shared constants and carriers for the roaming status / shutdown report block.
// assumes one 40 MHz clock domain on the register side; pin inputs are synchronised elsewhere.
package rssr_pkg;

	// apb register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ROAM = 8'h04;
	localparam logic [7:0] OFF_SHUT = 8'h08;
	localparam logic [7:0] OFF_LINK = 8'h0C;

	// control register field positions
	localparam int CTRL_IRS_BIT = 0;
	localparam int CTRL_MFC_BIT = 1;
	localparam int CTRL_NBC_BIT = 2;
	localparam int CTRL_RND_BIT = 3;
	localparam int CTRL_CND_BIT = 4;
	localparam int CTRL_MCM_BIT = 5;
	localparam int CTRL_SND_BIT = 6;
	localparam logic [6:0] CTRL_RST = 7'h00;

	// packet identifying top bytes
	localparam logic [7:0] ROAM_ID = 8'h60;
	localparam logic [7:0] SHUT_ID = 8'h7E;
	localparam int PKT_BITS = 32;

	// sticky flag indices
	localparam int FL_NBU = 0;
	localparam int FL_MAW = 1;
	localparam int FL_MBI = 2;
	localparam int FL_MS2 = 3;
	localparam int FL_MFI = 4;
	localparam int FL_MS1 = 5;
	localparam int FL_RSR = 6;
	localparam int FL_SCU = 7;
	localparam int FL_N = 8;
	// flags that may be set only once per frame
	localparam logic [7:0] FL_ONCE_MASK = 8'h86;

	// noise detect result codes
	localparam logic [1:0] NDR_NONE = 2'h0;
	localparam logic [1:0] NDR_ABANDON = 2'h1;
	localparam logic [1:0] NDR_SEEN = 2'h2;
	localparam logic [1:0] NDR_NOT_SEEN = 2'h3;

	// decoder events, all one-cycle pulses except the value fields
	typedef struct packed {
		logic resync;
		logic miss_sync1;
		logic fi_uncorr;
		logic miss_sync2;
		logic bi1_uncorr;
		logic addr_uncorr;
		logic fi_corr;
		logic net_bit;
		logic frame_start;
		logic bi1_ok;
		logic collapse_rx;
		logic [2:0] collapse_val;
		logic noise_done;
		logic noise_manual;
		logic [1:0] noise_code;
	} rssr_evt_t;

	// decoder timing and frame values sampled into the shutdown packet
	typedef struct packed {
		logic frame_number_valid_bit;
		logic [6:0] cf;
		logic [7:0] tnf_sync;
		logic [7:0] tnf_noise;
		logic carry_on;
		logic [6:0] next_assigned_frame_field;
	} rssr_shut_t;

endpackage

// >>> hdl/rssr_sync.sv
// rssr_sync: two flip-flop synchroniser for pin inputs.
// assumes inputs are asynchronous to clk_i; reset value is a parameter.
`timescale 1ns/1ps
module rssr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// >>> hdl/rssr_sticky.sv
// rssr_sticky: bank of sticky event flags with optional once-per-frame limit.
// assumes set, clear and frame_start are pulses on clk_i; a set beats a clear.
`timescale 1ns/1ps
module rssr_sticky #(
	parameter int N = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [N-1:0] set_i,
	input wire logic [N-1:0] clr_i,
	input wire logic [N-1:0] once_i,
	input wire logic frame_start_i,
	output logic [N-1:0] q_o
);
	logic [N-1:0] seen_q;

	for (genvar i = 0; i < N; i++) begin : g_flag
		logic set_ok;
		// a once-limited flag already raised in this frame stays quiet even if the host cleared it
		assign set_ok = set_i[i] & ~(once_i[i] & seen_q[i] & ~frame_start_i);

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				q_o[i] <= 1'b0;
			end else begin
				q_o[i] <= set_ok | (q_o[i] & ~clr_i[i]);
			end
		end

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				seen_q[i] <= 1'b0;
			end else if (frame_start_i) begin
				seen_q[i] <= set_i[i];
			end else if (set_i[i]) begin
				seen_q[i] <= 1'b1;
			end
		end
	end
endmodule

// >>> hdl/rssr_top.sv
// rssr_top: builds the roaming status and receiver shutdown packets, keeps
// the sticky roaming flags, and serialises packets to an spi master.
// assumes decoder events arrive on MCLK_I; spi pins are asynchronous.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rssr_top (
	input wire logic MCLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire rssr_pkg::rssr_evt_t DEC_EVT_I,
	input wire rssr_pkg::rssr_shut_t SHUT_SRC_I,
	input wire logic SYNC_MODE_I,
	input wire logic DECODE_ON_I,
	input wire logic FI_VALID_I,
	input wire logic SHUT_REQ_I,
	input wire logic SPI_SCK_I,
	input wire logic SPI_SS_N_I,
	output logic SPI_MISO_O,
	output logic SPI_MISO_OE_O,
	output logic READY_N_O,
	output logic FIV_O
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PROMPT,
		ST_SHIFT,
		ST_WAIT
	} rssr_state_t;

	rssr_state_t state_q;
	logic [6:0] ctrl_q;
	logic snd_pend_q;
	logic shut_pend_q;
	logic ms1_frame_q;
	logic bi1_frame_q;
	logic nbit_q;
	logic [2:0] rsc_q;
	logic [1:0] ndr_q;
	logic [rssr_pkg::FL_N-1:0] flags;
	logic [rssr_pkg::FL_N-1:0] flag_set;
	logic [rssr_pkg::FL_N-1:0] flag_clr;
	logic [31:0] roam_word;
	logic [31:0] shut_word;
	logic [31:0] snap_q;
	logic [31:0] shut_snap_q;
	logic [31:0] shreg_q;
	logic kind_roam_q;
	logic roam_done;
	logic [4:0] bit_cnt_q;
	logic [1:0] spi_s;
	logic sck_d_q;
	logic sck_rise;
	logic sck_fall;
	logic ss_n;
	logic noise_ok;
	logic roam_pend;
	logic apb_acc;
	logic apb_hit;
	logic [31:0] rd_mux;

	// ---------------- pin synchronisers ----------------
	rssr_sync #(
		.W(2),
		.RST_VAL(2'h2)
	) u_spi_sync (
		.clk_i(MCLK_I),
		.rst_n_i(NRST_I),
		.d_i({SPI_SS_N_I, SPI_SCK_I}),
		.q_o(spi_s)
	);

	assign ss_n = spi_s[1];

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sck_d_q <= 1'b0;
		end else begin
			sck_d_q <= spi_s[0];
		end
	end

	assign sck_rise = spi_s[0] & ~sck_d_q;
	assign sck_fall = ~spi_s[0] & sck_d_q;

	// ---------------- per-frame history ----------------
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ms1_frame_q <= 1'b0;
			bi1_frame_q <= 1'b0;
		end else if (DEC_EVT_I.frame_start) begin
			ms1_frame_q <= DEC_EVT_I.miss_sync1;
			bi1_frame_q <= DEC_EVT_I.bi1_ok;
		end else begin
			ms1_frame_q <= ms1_frame_q | DEC_EVT_I.miss_sync1;
			bi1_frame_q <= bi1_frame_q | DEC_EVT_I.bi1_ok;
		end
	end

	// ---------------- sticky flag sources ----------------
	always_comb begin
		flag_set = '0;
		flag_set[rssr_pkg::FL_RSR] = DEC_EVT_I.resync & ctrl_q[rssr_pkg::CTRL_IRS_BIT];
		flag_set[rssr_pkg::FL_MS1] = DEC_EVT_I.miss_sync1
			& ctrl_q[rssr_pkg::CTRL_MFC_BIT];
		flag_set[rssr_pkg::FL_MFI] = DEC_EVT_I.fi_uncorr
			& ctrl_q[rssr_pkg::CTRL_MFC_BIT];
		flag_set[rssr_pkg::FL_MS2] = DEC_EVT_I.miss_sync2
			& ctrl_q[rssr_pkg::CTRL_MFC_BIT];
		flag_set[rssr_pkg::FL_MBI] = DEC_EVT_I.bi1_uncorr
			& ctrl_q[rssr_pkg::CTRL_MFC_BIT];
		flag_set[rssr_pkg::FL_MAW] = DEC_EVT_I.addr_uncorr
			& ctrl_q[rssr_pkg::CTRL_MFC_BIT];
		// a frame whose first sync was missed has no frame info to report
		flag_set[rssr_pkg::FL_NBU] = DEC_EVT_I.fi_corr & ctrl_q[rssr_pkg::CTRL_NBC_BIT]
			& ~(ms1_frame_q & ~DEC_EVT_I.frame_start) & ~DEC_EVT_I.miss_sync1;
		flag_set[rssr_pkg::FL_SCU] = DEC_EVT_I.collapse_rx
			& ctrl_q[rssr_pkg::CTRL_MCM_BIT]
			& ((bi1_frame_q & ~DEC_EVT_I.frame_start) | DEC_EVT_I.bi1_ok);
	end

	// only the flags that went out in the packet are cleared, so events
	// raised during the transfer survive for the next packet
	always_comb begin
		flag_clr = '0;
		if (roam_done) begin
			flag_clr[rssr_pkg::FL_SCU] = snap_q[3];
			flag_clr[rssr_pkg::FL_RSR:rssr_pkg::FL_NBU] = snap_q[23:17];
		end
	end

	rssr_sticky #(
		.N(rssr_pkg::FL_N)
	) u_flags (
		.clk_i(MCLK_I),
		.rst_n_i(NRST_I),
		.set_i(flag_set),
		.clr_i(flag_clr),
		.once_i(rssr_pkg::FL_ONCE_MASK),
		.frame_start_i(DEC_EVT_I.frame_start),
		.q_o(flags)
	);

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			nbit_q <= 1'b0;
		end else if (DEC_EVT_I.fi_corr) begin
			nbit_q <= DEC_EVT_I.net_bit;
		end
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rsc_q <= 3'h0;
		end else if (flag_set[rssr_pkg::FL_SCU]) begin
			rsc_q <= DEC_EVT_I.collapse_val;
		end
	end

	// ---------------- noise detect result ----------------
	always_comb begin
		if (DEC_EVT_I.noise_manual) begin
			noise_ok = snd_pend_q;
		end else begin
			noise_ok = ~SYNC_MODE_I & ctrl_q[rssr_pkg::CTRL_RND_BIT];
		end
		if (ctrl_q[rssr_pkg::CTRL_CND_BIT] && DEC_EVT_I.noise_code != rssr_pkg::NDR_NOT_SEEN) begin
			noise_ok = 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ndr_q <= rssr_pkg::NDR_NONE;
		end else if (DEC_EVT_I.noise_done && noise_ok) begin
			ndr_q <= DEC_EVT_I.noise_code;
		end else if (roam_done && snap_q[9:8] != rssr_pkg::NDR_NONE) begin
			ndr_q <= rssr_pkg::NDR_NONE;
		end
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			snd_pend_q <= 1'b0;
		end else if (apb_acc && PWRITE_I && PADDR_I == rssr_pkg::OFF_CTRL
			&& PWDATA_I[rssr_pkg::CTRL_SND_BIT]) begin
			snd_pend_q <= 1'b1;
		end else if (DEC_EVT_I.noise_done && DEC_EVT_I.noise_manual) begin
			snd_pend_q <= 1'b0;
		end
	end

	// ---------------- frame info valid ----------------
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			FIV_O <= 1'b0;
		end else if (!DECODE_ON_I || !SYNC_MODE_I) begin
			FIV_O <= 1'b0;
		end else if (FI_VALID_I) begin
			FIV_O <= 1'b1;
		end
	end

	// ---------------- packet words ----------------
	assign roam_word = {rssr_pkg::ROAM_ID,
		flags[rssr_pkg::FL_RSR:rssr_pkg::FL_NBU], nbit_q,
		6'h00, ndr_q,
		4'h0, flags[rssr_pkg::FL_SCU], rsc_q};

	always_comb begin
		shut_word[31:24] = rssr_pkg::SHUT_ID;
		if (SYNC_MODE_I) begin
			shut_word[23] = SHUT_SRC_I.frame_number_valid_bit;
			shut_word[22:16] = SHUT_SRC_I.cf;
			shut_word[15:8] = SHUT_SRC_I.tnf_sync;
			shut_word[7] = 1'b0;
			shut_word[6:0] = SHUT_SRC_I.next_assigned_frame_field;
		end else begin
			shut_word[23] = 1'b0;
			shut_word[22:16] = 7'h00;
			shut_word[15:8] = SHUT_SRC_I.tnf_noise;
			shut_word[7] = SHUT_SRC_I.carry_on;
			shut_word[6:0] = 7'h00;
		end
	end

	assign roam_pend = (|flags) | (ndr_q != rssr_pkg::NDR_NONE);

	// a shutdown report that arrives while the previous one is taken is kept
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			shut_pend_q <= 1'b0;
		end else begin
			shut_pend_q <= SHUT_REQ_I | (shut_pend_q & ~(state_q == ST_IDLE));
		end
	end

	// ---------------- spi packet sequencer ----------------
	// ready falls in the same edge that latches the packet, which freezes
	// the time and frame fields exactly at the ready fall
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_q <= ST_IDLE;
			READY_N_O <= 1'b1;
			kind_roam_q <= 1'b0;
			snap_q <= 32'h0000_0000;
			bit_cnt_q <= 5'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (shut_pend_q) begin
						snap_q <= shut_word;
						kind_roam_q <= 1'b0;
						READY_N_O <= 1'b0;
						state_q <= ST_PROMPT;
					end else if (roam_pend) begin
						snap_q <= roam_word;
						kind_roam_q <= 1'b1;
						READY_N_O <= 1'b0;
						state_q <= ST_PROMPT;
					end
				end
				ST_PROMPT: begin
					bit_cnt_q <= 5'h00;
					if (!ss_n) begin
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (ss_n) begin
						// aborted transfer: packet stays and is offered again
						state_q <= ST_PROMPT;
					end else if (sck_rise) begin
						bit_cnt_q <= bit_cnt_q + 5'h01;
						if (bit_cnt_q == 5'(rssr_pkg::PKT_BITS - 1)) begin
							READY_N_O <= 1'b1;
							state_q <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					if (ss_n) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					READY_N_O <= 1'b1;
				end
			endcase
		end
	end

	assign roam_done = (state_q == ST_SHIFT) & ~ss_n & sck_rise & kind_roam_q
		& (bit_cnt_q == 5'(rssr_pkg::PKT_BITS - 1));

	// mode 0 style: first bit out at select, next bit on each falling edge
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			shreg_q <= 32'h0000_0000;
			SPI_MISO_O <= 1'b0;
		end else if (state_q == ST_PROMPT) begin
			shreg_q <= {snap_q[30:0], 1'b0};
			SPI_MISO_O <= snap_q[31];
		end else if (state_q == ST_SHIFT && sck_fall) begin
			shreg_q <= {shreg_q[30:0], 1'b0};
			SPI_MISO_O <= shreg_q[31];
		end
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			SPI_MISO_OE_O <= 1'b0;
		end else begin
			SPI_MISO_OE_O <= ~ss_n & (state_q == ST_SHIFT || state_q == ST_WAIT
				|| (state_q == ST_PROMPT));
		end
	end

	// ---------------- apb slave ----------------
	// one wait state: pready rises one cycle into the access phase
	assign apb_acc = PSEL_I & PENABLE_I & PREADY_O;
	assign apb_hit = (PADDR_I == rssr_pkg::OFF_CTRL) || (PADDR_I == rssr_pkg::OFF_ROAM)
		|| (PADDR_I == rssr_pkg::OFF_SHUT) || (PADDR_I == rssr_pkg::OFF_LINK);

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctrl_q <= rssr_pkg::CTRL_RST;
		end else if (apb_acc && PWRITE_I && PADDR_I == rssr_pkg::OFF_CTRL) begin
			ctrl_q <= {1'b0, PWDATA_I[5:0]};
		end
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			shut_snap_q <= 32'h0000_0000;
		end else if (state_q == ST_IDLE && shut_pend_q) begin
			shut_snap_q <= shut_word;
		end
	end

	always_comb begin
		case (PADDR_I)
			rssr_pkg::OFF_CTRL: rd_mux = {25'h0, snd_pend_q, ctrl_q[5:0]};
			rssr_pkg::OFF_ROAM: rd_mux = roam_word;
			rssr_pkg::OFF_SHUT: rd_mux = shut_snap_q;
			rssr_pkg::OFF_LINK: rd_mux = {24'h0, 1'b0, FIV_O, shut_pend_q, roam_pend,
				kind_roam_q, READY_N_O, state_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
		end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
			PREADY_O <= 1'b1;
			PSLVERR_O <= ~apb_hit;
			PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_mux;
		end else begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
	end
endmodule

// >>> tb/rssr_monitor.sv
// rssr_monitor: apb, link and frame-valid assertions on the rssr_top ports.
// assumes one MCLK_I domain; bound onto every rssr_top instance.
`timescale 1ns/1ps
module rssr_monitor (
	input wire logic MCLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic SYNC_MODE_I,
	input wire logic DECODE_ON_I,
	input wire logic FI_VALID_I,
	input wire logic SPI_SS_N_I,
	input wire logic SPI_MISO_O,
	input wire logic SPI_MISO_OE_O,
	input wire logic READY_N_O,
	input wire logic FIV_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!NRST_I);
	sequence s_access_wait;
		PSEL_I && PENABLE_I && !PREADY_O;
	endsequence
	// two cycles out of sync or off: the clear has had time to land
	sequence s_off_twice;
		(!SYNC_MODE_I || !DECODE_ON_I) [*2];
	endsequence
	AST_APB_ANSWER: assert property (s_access_wait |=> PREADY_O)
		else $error("apb access not answered after one wait cycle");
	AST_APB_PULSE: assert property (PREADY_O |=> !PREADY_O)
		else $error("pready held longer than one cycle");
	AST_SLVERR_WITH_READY: assert property (PSLVERR_O |-> PREADY_O)
		else $error("pslverr without pready");
	AST_FIV_SET: assert property (SYNC_MODE_I && DECODE_ON_I && FI_VALID_I |=> FIV_O)
		else $error("frame info valid not set");
	AST_FIV_CLEAR: assert property (s_off_twice |-> !FIV_O)
		else $error("frame info valid not cleared");
	AST_PROMPT_IDLE: assert property ($fell(READY_N_O) |-> $past(SPI_SS_N_I))
		else $error("prompt raised while link selected");
	AST_FIRST_BIT: assert property ($rose(SPI_MISO_OE_O) |-> !SPI_MISO_O)
		else $error("packet top bit not zero");
	AST_DONE_IN_FRAME: assert property ($rose(READY_N_O) |-> !SPI_SS_N_I && SPI_MISO_OE_O)
		else $error("prompt withdrawn outside a frame");
	AST_OE_DESELECT: assert property (SPI_SS_N_I [*4] |-> !SPI_MISO_OE_O)
		else $error("miso driven while deselected");
endmodule

bind rssr_top rssr_monitor u_mon (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.SYNC_MODE_I(SYNC_MODE_I), .DECODE_ON_I(DECODE_ON_I), .FI_VALID_I(FI_VALID_I),
	.SPI_SS_N_I(SPI_SS_N_I), .SPI_MISO_O(SPI_MISO_O), .SPI_MISO_OE_O(SPI_MISO_OE_O),
	.READY_N_O(READY_N_O), .FIV_O(FIV_O));

// >>> tb/rssr_host.sv
// rssr_host: behavioural spi master, mode 0, msb first, 200 ns clock.
// assumes the device prompts by pulling ready_n_i low.
`timescale 1ns/1ps
module rssr_host (
	input wire logic ready_n_i,
	input wire logic miso_i,
	output logic sck_o,
	output logic ss_n_o
);
	// link clock stands low outside frames
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
	end
	// nbits below 32 aborts the frame early
	task automatic read_pkt(input int nbits, output logic [31:0] word, output logic ok);
		int i;
		word = 32'h0;
		for (i = 0; i < 2000 && ready_n_i !== 1'b0; i++) #25;
		ok = (ready_n_i === 1'b0);
		if (ok) begin
			ss_n_o = 1'b0;
			#300;
			for (i = 0; i < nbits; i++) begin
				#100 sck_o = 1'b1;
				word = {word[30:0], miso_i};
				#100 sck_o = 1'b0;
			end
			#300 ss_n_o = 1'b1;
			#300;
		end
	endtask
endmodule

// >>> tb/rssr_top_test.sv
// rssr_top_test: random and directed checks of the roaming and shutdown reports.
// assumes rssr_host answers prompts; apb and decoder events are driven here.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
	$display("[FAIL] %s exp=%h got=%h", nm, ex, got); end end
module rssr_top_test;
	logic MCLK_I, NRST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, SYNC_MODE_I;
	logic DECODE_ON_I, FI_VALID_I, SHUT_REQ_I, SPI_SCK_I, SPI_SS_N_I, SPI_MISO_O;
	logic SPI_MISO_OE_O, READY_N_O, FIV_O, er, ok;
	logic [7:0] PADDR_I;
	logic [31:0] PWDATA_I, PRDATA_O, rd, w, idle_w;
	logic [6:0] ctl;
	rssr_pkg::rssr_evt_t DEC_EVT_I, ev, fs;
	rssr_pkg::rssr_shut_t SHUT_SRC_I, sh;
	int err_count = 0, cmp_count = 0, seed = 32'hdc85e426, k;
	rssr_top uut (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
		.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
		.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DEC_EVT_I(DEC_EVT_I),
		.SHUT_SRC_I(SHUT_SRC_I), .SYNC_MODE_I(SYNC_MODE_I), .DECODE_ON_I(DECODE_ON_I),
		.FI_VALID_I(FI_VALID_I), .SHUT_REQ_I(SHUT_REQ_I), .SPI_SCK_I(SPI_SCK_I),
		.SPI_SS_N_I(SPI_SS_N_I), .SPI_MISO_O(SPI_MISO_O), .SPI_MISO_OE_O(SPI_MISO_OE_O),
		.READY_N_O(READY_N_O), .FIV_O(FIV_O));
	rssr_host u_host (.ready_n_i(READY_N_O), .miso_i(SPI_MISO_O), .sck_o(SPI_SCK_I),
		.ss_n_o(SPI_SS_N_I));
	initial begin
		MCLK_I = 1'b0;
		forever #12.5 MCLK_I = ~MCLK_I;
	end
	function automatic logic [31:0] exp_roam(input logic [6:0] c, input rssr_pkg::rssr_evt_t e,
		input logic sy);
		logic [31:0] x;
		x = {rssr_pkg::ROAM_ID, 24'h0};
		x[23] = e.resync & c[rssr_pkg::CTRL_IRS_BIT];
		x[22:18] = {e.miss_sync1, e.fi_uncorr, e.miss_sync2, e.bi1_uncorr, e.addr_uncorr}
			& {5{c[rssr_pkg::CTRL_MFC_BIT]}};
		x[17] = e.fi_corr & c[rssr_pkg::CTRL_NBC_BIT] & ~e.miss_sync1;
		x[16] = x[17] & e.net_bit;
		if (e.noise_done && (e.noise_manual || (!sy && c[rssr_pkg::CTRL_RND_BIT]))
			&& (!c[rssr_pkg::CTRL_CND_BIT] || e.noise_code == rssr_pkg::NDR_NOT_SEEN))
			x[9:8] = e.noise_code;
		x[3] = e.collapse_rx & e.bi1_ok & c[rssr_pkg::CTRL_MCM_BIT];
		x[2:0] = x[3] ? e.collapse_val : 3'h0;
		return x;
	endfunction
	// network bit and collapse value mean nothing while their flag is clear
	function automatic logic [31:0] mk(input logic [31:0] x);
		return ~{15'h0, ~x[17], 13'h0, {3{~x[3]}}};
	endfunction
	function automatic logic [31:0] exp_shut(input rssr_pkg::rssr_shut_t s, input logic sy);
		return sy ? {rssr_pkg::SHUT_ID, s.frame_number_valid_bit, s.cf, s.tnf_sync, 1'b0, s.next_assigned_frame_field}
			: {rssr_pkg::SHUT_ID, 8'h0, s.tnf_noise, s.carry_on, 7'h0};
	endfunction
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge MCLK_I);
		PSEL_I <= 1'b1;
		PENABLE_I <= 1'b0;
		PWRITE_I <= wr;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge MCLK_I);
		PENABLE_I <= 1'b1;
		// data and error are taken at the same rising edge that sees pready high
		for (i = 0; i < 20; i++) begin
			@(posedge MCLK_I);
			if (PREADY_O === 1'b1) begin
				rd = PRDATA_O;
				er = PSLVERR_O;
				break;
			end
		end
		if (i == 20) begin
			err_count++;
			complete_run();
		end
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask
	task automatic pulse(input rssr_pkg::rssr_evt_t e);
		@(posedge MCLK_I);
		DEC_EVT_I <= e;
		@(posedge MCLK_I);
		DEC_EVT_I <= '0;
	endtask
	task automatic link(input int n);
		u_host.read_pkt(n, rd, ok);
		if (ok !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask
	initial begin
		{NRST_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = '0;
		{SYNC_MODE_I, DECODE_ON_I, FI_VALID_I, SHUT_REQ_I, DEC_EVT_I, SHUT_SRC_I} = '0;
		fs = '0;
		fs.frame_start = 1'b1;
		idle_w = {rssr_pkg::ROAM_ID, 24'h0};
		repeat (2) @(posedge MCLK_I);
		NRST_I <= 1'b1;
		DECODE_ON_I <= 1'b1;
		apb(1'b0, rssr_pkg::OFF_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0, rd)
		`CHK("mapped no err", 1'b0, er)
		apb(1'b0, rssr_pkg::OFF_LINK, 32'h0);
		`CHK("link reset", 32'h4, rd)
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		`CHK("unmapped err", 1'b1, er)
		ctl = 7'($random(seed)) & 7'h3F;
		apb(1'b1, rssr_pkg::OFF_CTRL, {25'h0, ctl});
		apb(1'b0, rssr_pkg::OFF_CTRL, 32'h0);
		`CHK("ctrl rw", {25'h0, ctl}, rd)
		for (k = 0; k < 14; k++) begin
			ev = rssr_pkg::rssr_evt_t'(18'($random(seed)));
			ev.frame_start = 1'b0;
			ctl = 7'($random(seed));
			ctl[6] = ev.noise_manual;
			@(posedge MCLK_I);
			SYNC_MODE_I <= k[1];
			apb(1'b1, rssr_pkg::OFF_CTRL, {25'h0, ctl});
			pulse(fs);
			pulse(ev);
			w = exp_roam(ctl, ev, SYNC_MODE_I);
			repeat (4) @(posedge MCLK_I);
			apb(1'b0, rssr_pkg::OFF_ROAM, 32'h0);
			`CHK("roam reg", w, rd & mk(w))
			`CHK("prompt", |{w[23:17], w[9:8], w[3]}, ~READY_N_O)
			if (READY_N_O === 1'b0) begin
				link(32);
				`CHK("roam link", w, rd & mk(w))
				apb(1'b0, rssr_pkg::OFF_ROAM, 32'h0);
				`CHK("roam clear", idle_w, rd & mk(idle_w))
			end
		end
		apb(1'b1, rssr_pkg::OFF_CTRL, 32'h22);
		ev = '0;
		{ev.bi1_uncorr, ev.addr_uncorr, ev.collapse_rx, ev.bi1_ok} = 4'hF;
		ev.collapse_val = 3'h5;
		w = exp_roam(7'h22, ev, 1'b1);
		pulse(fs);
		pulse(ev);
		link(8);
		link(32);
		`CHK("after abort", w, rd & mk(w))
		pulse(ev);
		repeat (4) @(posedge MCLK_I);
		apb(1'b0, rssr_pkg::OFF_ROAM, 32'h0);
		`CHK("once per frame", idle_w, rd & mk(idle_w))
		pulse(fs);
		pulse(ev);
		link(32);
		`CHK("next frame", w, rd & mk(w))
		for (k = 0; k < 4; k++) begin
			sh = rssr_pkg::rssr_shut_t'($random(seed));
			@(posedge MCLK_I);
			SHUT_SRC_I <= sh;
			SYNC_MODE_I <= k[0];
			@(posedge MCLK_I);
			SHUT_REQ_I <= 1'b1;
			@(posedge MCLK_I);
			SHUT_REQ_I <= 1'b0;
			for (int i = 0; i < 40 && READY_N_O !== 1'b0; i++) @(negedge MCLK_I);
			@(posedge MCLK_I);
			SHUT_SRC_I <= ~sh;
			w = exp_shut(sh, k[0]);
			link(32);
			`CHK("shut link", w, rd)
			apb(1'b0, rssr_pkg::OFF_SHUT, 32'h0);
			`CHK("shut reg", w, rd)
		end
		@(posedge MCLK_I);
		SYNC_MODE_I <= 1'b1;
		FI_VALID_I <= 1'b1;
		@(posedge MCLK_I);
		FI_VALID_I <= 1'b0;
		@(negedge MCLK_I);
		`CHK("fiv set", 1'b1, FIV_O)
		@(posedge MCLK_I);
		DECODE_ON_I <= 1'b0;
		repeat (2) @(negedge MCLK_I);
		`CHK("fiv clear", 1'b0, FIV_O)
		complete_run();
	end
endmodule
